// ===== design/xiu_irq_top.sv
// Purpose: transfer unit interrupt status with write-one clear
// Assumes: event inputs synchronous to mclk, one-cycle pulses
// Notes: set wins over clear in the same cycle
`timescale 1ns/1ps
module xiu_irq_top (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // apb
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transfer unit events, index 0 is unit 1
  input xiu_pkg::xiu_events_t unit_ev [xiu_pkg::UNITS],
  input wire logic [xiu_pkg::UNITS-1:0] done_irq_req,
  // interrupt
  output logic irq
);
  // ==========================================================
  // bus decode
  logic clr_we;
  logic mask_we;
  logic rd_status;
  logic rd_mask;
  xiu_pkg::xiu_apb_req_t req;
  assign req = '{paddr: paddr, psel: psel, penable: penable,
                 pwrite: pwrite, pwdata: pwdata};

  xiu_apb_slave u_apb (
    .req(req),
    .pready(pready),
    .pslverr(pslverr),
    .clr_we(clr_we),
    .mask_we(mask_we),
    .rd_status(rd_status),
    .rd_mask(rd_mask)
  );

  // ==========================================================
  // event mapping
  logic [31:0] set_all;
  genvar g;
  generate
    for (g = 0; g < xiu_pkg::UNITS; g++) begin : g_unit
      xiu_unit_events u_ev (
        .ev(unit_ev[g]),
        .done_irq_req(done_irq_req[g]),
        .set_vec(set_all[g*8 +: 8])
      );
    end
  endgenerate

  // ==========================================================
  // status, mask, interrupt
  logic [31:0] status_r;
  logic [31:0] status_nxt;
  logic [31:0] mask_r;
  logic [31:0] clr_vec;

  always_comb begin
    clr_vec = clr_we ? pwdata : 32'h0000_0000;
    status_nxt = (status_r & ~clr_vec) | set_all;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      status_r <= xiu_pkg::STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mask_r <= xiu_pkg::MASK_RST;
    end else if (mask_we) begin
      mask_r <= pwdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq <= 1'h0;
    end else begin
      // a mask write counts at the same edge
      irq <= |(status_nxt & (mask_we ? pwdata : mask_r));
    end
  end

  // ==========================================================
  // read data, loaded in the setup phase
  logic [31:0] rd_mux;
  logic [31:0] prdata_r;

  always_comb begin
    if (rd_status) begin
      rd_mux = status_r;
    end else if (rd_mask) begin
      rd_mux = mask_r;
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // held through the access phase so prdata comes from a flop
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_r <= rd_mux;
    end
  end

  assign prdata = prdata_r;

  // ==========================================================
  // checks
  property p_set_wins;
    @(posedge mclk) disable iff (!reset_n)
      set_all[xiu_pkg::BIT_CREDIT] |=> status_r[xiu_pkg::BIT_CREDIT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost");

  property p_clear;
    @(posedge mclk) disable iff (!reset_n)
      (clr_we && pwdata[3] && !set_all[3]) |=> !status_r[3];
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");

  property p_zero_keeps;
    @(posedge mclk) disable iff (!reset_n)
      (clr_we && !pwdata[5] && status_r[5]) |=> status_r[5];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("zero cleared");

  property p_sticky;
    @(posedge mclk) disable iff (!reset_n)
      (status_r[1] && !clr_we) |=> status_r[1];
  endproperty
  a_sticky: assert property (p_sticky) else $error("bit dropped");

  property p_done_gate;
    @(posedge mclk) disable iff (!reset_n)
      (unit_ev[0].done_ok && !done_irq_req[0] && !status_r[0])
        |=> !status_r[0];
  endproperty
  a_done_gate: assert property (p_done_gate) else $error("done ungated");

  property p_unit2;
    @(posedge mclk) disable iff (!reset_n)
      unit_ev[1].timeout |=> status_r[9];
  endproperty
  a_unit2: assert property (p_unit2) else $error("unit2 map");

  property p_unit3;
    @(posedge mclk) disable iff (!reset_n)
      unit_ev[2].credit_short |=> status_r[23];
  endproperty
  a_unit3: assert property (p_unit3) else $error("unit3 map");

  property p_dma;
    @(posedge mclk) disable iff (!reset_n)
      unit_ev[0].dma_error |=> status_r[xiu_pkg::BIT_DMA_ERR];
  endproperty
  a_dma: assert property (p_dma) else $error("dma map");

  property p_rise;
    @(posedge mclk) disable iff (!reset_n)
      $rose(status_r[7]) |-> $past(set_all[7]);
  endproperty
  a_rise: assert property (p_rise) else $error("spurious set");

  property p_irq;
    @(posedge mclk) disable iff (!reset_n)
      irq == |(status_r & mask_r);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_credit;
    @(posedge mclk) disable iff (!reset_n)
      unit_ev[0].credit_short |=> status_r[xiu_pkg::BIT_CREDIT];
  endproperty
  a_credit: assert property (p_credit) else $error("credit map");

  property p_retry;
    @(posedge mclk) disable iff (!reset_n)
      unit_ev[0].retry_or_sem_busy |=> status_r[xiu_pkg::BIT_RETRY];
  endproperty
  a_retry: assert property (p_retry) else $error("retry map");

  property p_bad_enc;
    @(posedge mclk) disable iff (!reset_n)
      unit_ev[0].bad_encoding |=> status_r[xiu_pkg::BIT_BAD_ENC];
  endproperty
  a_bad_enc: assert property (p_bad_enc) else $error("encoding map");

  property p_err_resp;
    @(posedge mclk) disable iff (!reset_n)
      unit_ev[0].error_response |=> status_r[xiu_pkg::BIT_ERR_RESP];
  endproperty
  a_err_resp: assert property (p_err_resp) else $error("resp map");

  property p_flow_off;
    @(posedge mclk) disable iff (!reset_n)
      unit_ev[0].flow_off |=> status_r[xiu_pkg::BIT_FLOW_OFF];
  endproperty
  a_flow_off: assert property (p_flow_off) else $error("xoff map");

  property p_timeout;
    @(posedge mclk) disable iff (!reset_n)
      unit_ev[0].timeout |=> status_r[xiu_pkg::BIT_TIMEOUT];
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout map");

  property p_done_set;
    @(posedge mclk) disable iff (!reset_n)
      (unit_ev[0].done_ok && done_irq_req[0])
        |=> status_r[xiu_pkg::BIT_DONE];
  endproperty
  a_done_set: assert property (p_done_set) else $error("done map");

  property p_quiet;
    @(posedge mclk) disable iff (!reset_n)
      (set_all == 32'h0000_0000)
        |=> ((status_r & ~$past(status_r)) == 32'h0000_0000);
  endproperty
  a_quiet: assert property (p_quiet) else $error("bit set from nothing");

  property p_clr_all;
    @(posedge mclk) disable iff (!reset_n)
      (clr_we && ((pwdata & set_all) == 32'h0000_0000))
        |=> ((status_r & $past(pwdata)) == 32'h0000_0000);
  endproperty
  a_clr_all: assert property (p_clr_all) else $error("missed");

  property p_keep;
    @(posedge mclk) disable iff (!reset_n)
      (status_r != 32'h0000_0000)
        |=> (($past(status_r) & ~$past(clr_vec) & ~status_r)
             == 32'h0000_0000);
  endproperty
  a_keep: assert property (p_keep) else $error("bit lost");

  property p_set_all;
    @(posedge mclk) disable iff (!reset_n)
      (set_all != 32'h0000_0000)
        |=> ((status_r & $past(set_all)) == $past(set_all));
  endproperty
  a_set_all: assert property (p_set_all) else $error("set dropped");

  property p_reset;
    @(posedge mclk)
      !reset_n |=> (status_r == xiu_pkg::STATUS_RST) &&
        (mask_r == xiu_pkg::MASK_RST) && !irq;
  endproperty
  a_reset: assert property (p_reset) else $error("reset value");

  property p_rd_status;
    @(posedge mclk) disable iff (!reset_n)
      (psel && !penable && paddr == xiu_pkg::STATUS_OFF)
        |=> (prdata == $past(status_r));
  endproperty
  a_rd_status: assert property (p_rd_status) else $error("read data");

  property p_rd_clear;
    @(posedge mclk) disable iff (!reset_n)
      (psel && !penable && paddr == xiu_pkg::CLEAR_OFF)
        |=> (prdata == 32'h0000_0000);
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("clear read");

  property p_hold;
    @(posedge mclk) disable iff (!reset_n)
      (clr_vec == 32'h0000_0000 && set_all == 32'h0000_0000)
        |=> (status_r == $past(status_r));
  endproperty
  a_hold: assert property (p_hold) else $error("status moved");

  property p_unit4_gate;
    @(posedge mclk) disable iff (!reset_n)
      (unit_ev[3].done_ok && !done_irq_req[3] && !status_r[24])
        |=> !status_r[24];
  endproperty
  a_unit4_gate: assert property (p_unit4_gate) else $error("gate");

  property p_unit3_clear;
    @(posedge mclk) disable iff (!reset_n)
      (clr_we && pwdata[20] && !set_all[20]) |=> !status_r[20];
  endproperty
  a_unit3_clear: assert property (p_unit3_clear) else $error("u3 clr");

  // ==========================================================
  // cover points
  c_clear: cover property (@(posedge mclk) clr_we && |pwdata);
  c_irq: cover property (@(posedge mclk) $rose(irq));
  c_race: cover property (@(posedge mclk) clr_we && |(pwdata & set_all));
  c_gated: cover property (@(posedge mclk)
    unit_ev[0].done_ok && !done_irq_req[0]);
  c_err: cover property (@(posedge mclk) pslverr);
endmodule

// ===== design/xiu_pkg.sv
// Purpose: shared constants and types for the transfer unit irq block
// Assumes: APB slave, 32-bit data, word aligned registers
// Notes: status offset and mask offset are local choices
package xiu_pkg;
  localparam logic [11:0] STATUS_OFF = 12'h260;
  localparam logic [11:0] CLEAR_OFF = 12'h268;
  localparam logic [11:0] MASK_OFF = 12'h26C;
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam int UNITS = 4;
  localparam int EV_W = 8;
  localparam int BIT_DONE = 0;
  localparam int BIT_TIMEOUT = 1;
  localparam int BIT_FLOW_OFF = 2;
  localparam int BIT_ERR_RESP = 3;
  localparam int BIT_BAD_ENC = 4;
  localparam int BIT_DMA_ERR = 5;
  localparam int BIT_RETRY = 6;
  localparam int BIT_CREDIT = 7;

  // one transfer unit's event pulses, bit order as in status
  typedef struct packed {
    logic credit_short;
    logic retry_or_sem_busy;
    logic dma_error;
    logic bad_encoding;
    logic error_response;
    logic flow_off;
    logic timeout;
    logic done_ok;
  } xiu_events_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } xiu_apb_req_t;
endpackage

// ===== design/xiu_unit_events.sv
// Purpose: map one transfer unit's events to status set bits
// Assumes: events are one-cycle pulses
// Notes: done_ok gated by the request's interrupt-request bit
`timescale 1ns/1ps
module xiu_unit_events (
  // events in
  input xiu_pkg::xiu_events_t ev,
  input wire logic done_irq_req,
  // set vector out
  output logic [7:0] set_vec
);
  always_comb begin
    set_vec = ev;
    set_vec[xiu_pkg::BIT_DONE] = ev.done_ok & done_irq_req;
  end
endmodule

// ===== design/xiu_apb_slave.sv
// Purpose: APB decode for status, clear and mask registers
// Assumes: zero wait states, pslverr on unmapped address
// Notes: clear register reads as zero
`timescale 1ns/1ps
module xiu_apb_slave (
  // apb
  input xiu_pkg::xiu_apb_req_t req,
  output logic pready,
  output logic pslverr,
  // register strobes
  output logic clr_we,
  output logic mask_we,
  output logic rd_status,
  output logic rd_mask
);
  logic acc;
  logic hit;
  always_comb begin
    acc = req.psel & req.penable;
    hit = (req.paddr == xiu_pkg::STATUS_OFF) |
          (req.paddr == xiu_pkg::CLEAR_OFF) |
          (req.paddr == xiu_pkg::MASK_OFF);
    pready = 1'h1;
    pslverr = acc & ~hit;
    clr_we = acc & req.pwrite & (req.paddr == xiu_pkg::CLEAR_OFF);
    mask_we = acc & req.pwrite & (req.paddr == xiu_pkg::MASK_OFF);
    rd_status = req.paddr == xiu_pkg::STATUS_OFF;
    rd_mask = req.paddr == xiu_pkg::MASK_OFF;
  end
endmodule

// ===== test/tb.sv
// Purpose: self-checking bench for the transfer unit irq block
// Assumes: zero wait APB slave, event pulses sampled on mclk
// Notes: table rows cover each event bit, hand tests the edges
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [1:0] u;
    logic [7:0] ev;
    logic req;
    logic [31:0] exp;
  } xiu_row_t;
  logic mclk = 1'h0;
  logic reset_n = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  xiu_pkg::xiu_events_t unit_ev [xiu_pkg::UNITS];
  logic [xiu_pkg::UNITS-1:0] done_irq_req = 4'h0;
  logic irq;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int n_compared = 0;
  xiu_row_t rows [12] = '{
    '{2'h0, 8'h80, 1'h1, 32'h0000_0080},
    '{2'h0, 8'h40, 1'h1, 32'h0000_0040},
    '{2'h0, 8'h20, 1'h1, 32'h0000_0020},
    '{2'h0, 8'h10, 1'h1, 32'h0000_0010},
    '{2'h0, 8'h08, 1'h1, 32'h0000_0008},
    '{2'h0, 8'h04, 1'h1, 32'h0000_0004},
    '{2'h0, 8'h02, 1'h1, 32'h0000_0002},
    '{2'h0, 8'h01, 1'h1, 32'h0000_0001},
    '{2'h0, 8'h01, 1'h0, 32'h0000_0000},
    '{2'h1, 8'hFF, 1'h1, 32'h0000_FF00},
    '{2'h2, 8'hFF, 1'h1, 32'h00FF_0000},
    '{2'h3, 8'h81, 1'h0, 32'h8000_0000}};
  always #50 mclk = ~mclk;
  xiu_irq_top xiu_irq_top_inst (.mclk(mclk), .reset_n(reset_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .unit_ev(unit_ev), .done_irq_req(done_irq_req),
    .irq(irq));
  // ==========================================
  // tasks
  task results;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ev is driven on unit 1 during the access phase
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [7:0] ev);
    int i;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    unit_ev[0] <= xiu_pkg::xiu_events_t'(ev);
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (pready !== 1'h1 && i < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    unit_ev[0] <= '0;
    if (i >= 16) begin
      failures++;
      $display("Error at %0t: no pready", $time);
      results();
    end
  endtask
  task rds;
    apb(1'h0, xiu_pkg::STATUS_OFF, 32'h0, 8'h00);
  endtask
  task pulse(input logic [1:0] u, input logic [7:0] ev, input logic r);
    @(posedge mclk);
    unit_ev[u] <= xiu_pkg::xiu_events_t'(ev);
    done_irq_req[u] <= r;
    @(posedge mclk);
    unit_ev[u] <= '0;
  endtask
  // ==========================================
  // sequence
  initial begin
    foreach (unit_ev[k]) unit_ev[k] = '0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'h1;
    apb(1'h1, xiu_pkg::MASK_OFF, 32'hFFFF_FFFF, 8'h00);
    foreach (rows[k]) begin
      pulse(rows[k].u, rows[k].ev, rows[k].req);
      rds();
      chk(rd, rows[k].exp);
      chk({31'h0, irq}, {31'h0, rows[k].exp != 32'h0});
      apb(1'h1, xiu_pkg::CLEAR_OFF, 32'hFFFF_FFFF, 8'h00);
      rds();
      chk(rd, 32'h0);
    end
    $display("row tests done");
    pulse(2'h0, 8'h05, 1'h1);
    apb(1'h1, xiu_pkg::CLEAR_OFF, 32'h0, 8'h00);
    rds();
    chk(rd, 32'h5);
    apb(1'h1, xiu_pkg::CLEAR_OFF, 32'h4, 8'h00);
    rds();
    chk(rd, 32'h1);
    apb(1'h1, xiu_pkg::CLEAR_OFF, 32'h1, 8'h01);
    rds();
    chk(rd, 32'h1);
    apb(1'h0, xiu_pkg::CLEAR_OFF, 32'h0, 8'h00);
    chk(rd, 32'h0);
    $display("clear tests done");
    apb(1'h1, xiu_pkg::MASK_OFF, 32'h0000_FF00, 8'h00);
    apb(1'h0, xiu_pkg::MASK_OFF, 32'h0, 8'h00);
    chk(rd, 32'h0000_FF00);
    apb(1'h1, xiu_pkg::CLEAR_OFF, 32'h1, 8'h02);
    rds();
    chk({31'h0, irq}, 32'h0);
    pulse(2'h1, 8'h02, 1'h1);
    apb(1'h1, xiu_pkg::STATUS_OFF, 32'h0, 8'h00);
    rds();
    chk(rd, 32'h0202);
    chk({31'h0, irq}, 32'h1);
    apb(1'h1, 12'h300, 32'hFFFF_FFFF, 8'h00);
    apb(1'h0, 12'h300, 32'h0, 8'h00);
    chk({err, rd[30:0]}, 32'h8000_0000);
    $display("mask tests done");
    @(posedge mclk);
    reset_n <= 1'h0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'h1;
    rds();
    chk(rd, xiu_pkg::STATUS_RST);
    chk({31'h0, irq}, 32'h0);
    apb(1'h0, xiu_pkg::MASK_OFF, 32'h0, 8'h00);
    chk(rd, xiu_pkg::MASK_RST);
    $display("reset tests done");
    results();
  end
endmodule
